// ---- core/ptoc_top.v ----
// Purpose: pad test override control with apb register access
// Assumes: apb slave, 32-bit data, registers at index times four
// Notes: 20 pads, lower 16 values come from an external value port
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`include "ptoc_defs.vh"
// What this block does
// [RULE_01] With override on and direction output, the four upper pads follow bits 3-0.
// [RULE_02] While bit 4 is set, pad direction comes from bit 5 and levels from bits 3-0 and the lower_value port.
// [RULE_03] Bit 5 is an active-low output enable used only in override mode; 0 makes outputs.
// [RULE_04] Pull field bits 8-7 decode as none, up, down or both.
// [RULE_05] Bit 6 set applies the test pull field instead of functional pulls.
// [RULE_06] Bits 13-9 select the clock output pad edge rate.
// [RULE_07] Bits 9-5 of the second register select the receive pad edge rate.
// [RULE_08] With override on and direction input, the status bits show sensed pin levels.
// [RULE_09] With override off and bit 6 clear, pads stay under functional control.
module ptoc_top #(
    parameter NPADS = 20,
    parameter NLOW = 16
) (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire [NLOW-1:0] lower_value,
    input wire [NPADS-1:0] func_out,
    input wire [NPADS-1:0] func_oe,
    input wire [NPADS-1:0] func_pu,
    input wire [NPADS-1:0] func_pd,
    input wire [NPADS-1:0] pad_in,
    output reg [NPADS-1:0] pad_out,
    output reg [NPADS-1:0] pad_oe,
    output wire [NPADS-1:0] pad_pu,
    output wire [NPADS-1:0] pad_pd,
    output reg [NPADS-1:0] func_in,
    output reg [4:0] clock_output_pad_slew,
    output reg [4:0] rx_pad_slew
);
    // ----------------------------------------
    // register bank
    // ----------------------------------------
    reg [15:0] ctrl_reg;
    reg [15:0] slew_reg;
    reg [15:0] in_low_reg;
    reg [3:0] in_up_reg;
    wire [NPADS-1:0] pin_level;
    wire [13:0] word_idx;
    wire hit_ctrl;
    wire hit_slew;
    wire hit_inl;
    wire hit_inu;
    wire hit_any;
    wire wr_en;
    wire rd_en;
    wire force_on;
    wire drive_out;
    wire sense_in;

    function [15:0] ptoc_merge;
        input [15:0] old_val;
        input [31:0] wdata;
        input [3:0] strb;
        input [15:0] wmask;
        reg [15:0] lane;
        begin
            lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
            ptoc_merge = (old_val & ~lane) | (wdata[15:0] & lane);
        end
    endfunction

    assign word_idx = paddr[15:2];
    assign hit_ctrl = (word_idx == {2'h0, `PTOC_IDX_CTRL});
    assign hit_slew = (word_idx == {2'h0, `PTOC_IDX_SLEW});
    assign hit_inl = (word_idx == {2'h0, `PTOC_IDX_INL});
    assign hit_inu = (word_idx == {2'h0, `PTOC_IDX_INU});
    assign hit_any = hit_ctrl | hit_slew | hit_inl | hit_inu;
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    assign force_on = ctrl_reg[`PTOC_FORCE_BIT];
    assign drive_out = force_on & ~ctrl_reg[`PTOC_OEN_BIT]; // [RULE_03]
    assign sense_in = force_on & ctrl_reg[`PTOC_OEN_BIT];

    // writes to read-only status words are ignored, unmapped raise pslverr
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrl_reg <= `PTOC_RST_CTRL;
            slew_reg <= `PTOC_RST_SLEW;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                ctrl_reg <= ptoc_merge(ctrl_reg, pwdata, pstrb, `PTOC_CTRL_WMASK);
            end
            if (hit_slew) begin
                slew_reg <= ptoc_merge(slew_reg, pwdata, pstrb, `PTOC_SLEW_WMASK);
            end
        end
    end

    // read data registered in setup, valid in the access cycle
    always @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            pslverr <= ~hit_any;
            if (rd_en & hit_ctrl) begin
                prdata <= {16'h0000, ctrl_reg};
            end else if (rd_en & hit_slew) begin
                prdata <= {16'h0000, slew_reg};
            end else if (rd_en & hit_inl) begin
                prdata <= {16'h0000, in_low_reg};
            end else if (rd_en & hit_inu) begin
                prdata <= {28'h0000000, in_up_reg};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // pad input sensing
    // ----------------------------------------
    ptoc_sync #(
        .WIDTH(NPADS)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(pad_in),
        .level_out(pin_level)
    );

    // status holds last sample once the pads leave input test mode
    always @(posedge ref_clk) begin
        if (rst) begin
            in_low_reg <= 16'h0000;
            in_up_reg <= 4'h0;
            func_in <= {NPADS{1'b0}};
        end else begin
            func_in <= pin_level;
            if (sense_in) begin
                in_low_reg <= pin_level[NLOW-1:0]; // [RULE_08]
                in_up_reg <= pin_level[NPADS-1:NLOW];
            end
        end
    end

    // ----------------------------------------
    // pad drive and direction
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            pad_out <= {NPADS{1'b0}};
            pad_oe <= {NPADS{1'b0}};
        end else if (force_on) begin
            pad_oe <= {NPADS{drive_out}}; // [RULE_02]
            pad_out <= {ctrl_reg[`PTOC_VAL_HI:`PTOC_VAL_LO], lower_value}; // [RULE_01]
        end else begin
            pad_oe <= func_oe; // [RULE_09]
            pad_out <= func_out;
        end
    end

    // ----------------------------------------
    // pulls and slew
    // ----------------------------------------
    ptoc_pull #(
        .WIDTH(NPADS)
    ) u_pull (
        .pull_force(ctrl_reg[`PTOC_PFORCE_BIT]),
        .pull_code(ctrl_reg[`PTOC_PULL_HI:`PTOC_PULL_LO]),
        .func_pu(func_pu),
        .func_pd(func_pd),
        .pad_pu(pad_pu),
        .pad_pd(pad_pd)
    );

    always @(posedge ref_clk) begin
        if (rst) begin
            clock_output_pad_slew <= `PTOC_CSLEW_DEF;
            rx_pad_slew <= `PTOC_RSLEW_DEF;
        end else begin
            clock_output_pad_slew <= ctrl_reg[`PTOC_CSLEW_HI:`PTOC_CSLEW_LO]; // [RULE_06]
            rx_pad_slew <= slew_reg[`PTOC_RSLEW_HI:`PTOC_RSLEW_LO]; // [RULE_07]
        end
    end
endmodule

// ---- core/ptoc_defs.vh ----
// Purpose: constants for the pad test override control block
// Assumes: register index times four gives the apb byte address
// Notes: definitions only
`ifndef PTOC_DEFS_VH
`define PTOC_DEFS_VH
`define PTOC_IDX_CTRL 12'h455
`define PTOC_IDX_SLEW 12'h456
`define PTOC_IDX_INL 12'h457
`define PTOC_IDX_INU 12'h458
`define PTOC_RST_CTRL 16'h0000
`define PTOC_RST_SLEW 16'h0108
`define PTOC_CTRL_WMASK 16'h3fff
`define PTOC_SLEW_WMASK 16'h03ff
`define PTOC_VAL_HI 3
`define PTOC_VAL_LO 0
`define PTOC_FORCE_BIT 4
`define PTOC_OEN_BIT 5
`define PTOC_PFORCE_BIT 6
`define PTOC_PULL_HI 8
`define PTOC_PULL_LO 7
`define PTOC_CSLEW_HI 13
`define PTOC_CSLEW_LO 9
`define PTOC_RSLEW_HI 9
`define PTOC_RSLEW_LO 5
`define PTOC_PULL_NONE 2'h0
`define PTOC_PULL_UP 2'h1
`define PTOC_PULL_DOWN 2'h2
`define PTOC_PULL_BOTH 2'h3
`define PTOC_CSLEW_DEF 5'h00
`define PTOC_CSLEW_SLOW 5'h01
`define PTOC_CSLEW_FAST 5'h02
`define PTOC_RSLEW_DEF 5'h08
`define PTOC_RSLEW_MED 5'h0a
`define PTOC_RSLEW_SLOWEST 5'h0b
`endif

// ---- core/ptoc_sync.v ----
// Purpose: three-stage synchroniser for pad input levels
// Assumes: inputs asynchronous to ref_clk
// Notes: a change is taken once stages two and three agree
`timescale 1ns/1ns
module ptoc_sync #(
    parameter WIDTH = 20
) (
    input wire ref_clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] level_out
);
    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    integer i;
    always @(posedge ref_clk) begin
        if (rst) begin
            s1_reg <= {WIDTH{1'b0}};
            s2_reg <= {WIDTH{1'b0}};
            s3_reg <= {WIDTH{1'b0}};
            level_out <= {WIDTH{1'b0}};
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // hold last value while stages disagree, filters one-cycle glitches
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    level_out[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule

// ---- core/ptoc_pull.v ----
// Purpose: pull decode and override select for all pads
// Assumes: functional pull enables come from the same clock domain
// Notes: purely combinational
`timescale 1ns/1ns
`include "ptoc_defs.vh"
module ptoc_pull #(
    parameter WIDTH = 20
) (
    input wire pull_force,
    input wire [1:0] pull_code,
    input wire [WIDTH-1:0] func_pu,
    input wire [WIDTH-1:0] func_pd,
    output reg [WIDTH-1:0] pad_pu,
    output reg [WIDTH-1:0] pad_pd
);
    reg tm_pu;
    reg tm_pd;
    always @* begin
        case (pull_code)
            `PTOC_PULL_NONE: begin tm_pu = 1'b0; tm_pd = 1'b0; end // [RULE_04]
            `PTOC_PULL_UP: begin tm_pu = 1'b1; tm_pd = 1'b0; end
            `PTOC_PULL_DOWN: begin tm_pu = 1'b0; tm_pd = 1'b1; end
            default: begin tm_pu = 1'b1; tm_pd = 1'b1; end
        endcase
        if (pull_force) begin
            pad_pu = {WIDTH{tm_pu}}; // [RULE_05]
            pad_pd = {WIDTH{tm_pd}};
        end else begin
            pad_pu = func_pu; // [RULE_09]
            pad_pd = func_pd;
        end
    end
endmodule

// ---- tb/ptoc_top_sva.sv ----
// Purpose: assertions for pad test override control
// Assumes: apb writes shadowed here with the block's write masks
// Notes: registered outputs checked one edge after the shadow, pulls in the same cycle
`timescale 1ns/1ns
module ptoc_top_sva #(parameter NPADS = 20, parameter NLOW = 16) (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [NLOW-1:0] lower_value,
    input wire [NPADS-1:0] func_out,
    input wire [NPADS-1:0] func_oe,
    input wire [NPADS-1:0] func_pu,
    input wire [NPADS-1:0] func_pd,
    input wire [NPADS-1:0] pad_out,
    input wire [NPADS-1:0] pad_oe,
    input wire [NPADS-1:0] pad_pu,
    input wire [NPADS-1:0] pad_pd,
    input wire [4:0] clock_output_pad_slew,
    input wire [4:0] rx_pad_slew
);
logic [15:0] c;
logic [4:0] s;
wire wr = psel && penable && pwrite;
always @(posedge ref_clk) begin
    if (rst) begin
        c <= 16'h0000;
        s <= 5'h08;
    end else if (wr && paddr == 16'h1154) begin
        if (pstrb[0]) c[7:0] <= pwdata[7:0];
        if (pstrb[1]) c[15:8] <= pwdata[15:8] & 8'h3f;
    end else if (wr && paddr == 16'h1158) begin
        if (pstrb[0]) s[2:0] <= pwdata[7:5];
        if (pstrb[1]) s[4:3] <= pwdata[9:8];
    end
end
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
chk_drive_dir: assert property (c[4] && !c[5] |=> &pad_oe)
    else $error("pads not driven in test output mode");
chk_input_dir: assert property (c[4] && c[5] |=> pad_oe == '0)
    else $error("pads driven in test input mode");
chk_upper_val: assert property (c[4] && !c[5] |=> pad_out[NPADS-1:NLOW] == $past(c[3:0]))
    else $error("upper pad level wrong");
chk_lower_val: assert property (c[4] |=> pad_out[NLOW-1:0] == $past(lower_value))
    else $error("lower pad level wrong");
chk_func_pass: assert property (!c[4] |=> pad_oe == $past(func_oe) && pad_out == $past(func_out))
    else $error("functional control not passed");
chk_pull_func: assert property (!c[6] |-> pad_pu == func_pu && pad_pd == func_pd)
    else $error("functional pull not passed");
chk_pull_code: assert property (c[6] |-> pad_pu == {NPADS{c[7]}} && pad_pd == {NPADS{c[8]}})
    else $error("pull decode wrong");
chk_clk_slew: assert property (1 |=> clock_output_pad_slew == $past(c[13:9]))
    else $error("clock pad slew wrong");
chk_rx_slew: assert property (1 |=> rx_pad_slew == $past(s))
    else $error("receive pad slew wrong");
cover property (c[4] && !c[5]);
cover property (c[4] && c[5]);
cover property (c[6] && c[8:7] == 2'h3);
endmodule
bind ptoc_top ptoc_top_sva #(.NPADS(NPADS), .NLOW(NLOW)) chk (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .lower_value(lower_value), .func_out(func_out), .func_oe(func_oe),
    .func_pu(func_pu), .func_pd(func_pd), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pu(pad_pu), .pad_pd(pad_pd), .clock_output_pad_slew(clock_output_pad_slew),
    .rx_pad_slew(rx_pad_slew));

// ---- tb/ptoc_top_tb.sv ----
// Purpose: directed bench for pad test override control
// Assumes: byte address is register index times four
// Notes: each scenario task judges its own results
`timescale 1ns/1ns
module ptoc_top_tb;
logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
logic [15:0] paddr = '0, lower_value = '0;
logic [31:0] pwdata = '0, rdv;
logic [19:0] func_out = '0, func_oe = '0, func_pu = 20'h0f0f0, func_pd = 20'h30303;
logic [19:0] pad_in = '0;
wire pready, pslverr;
wire [31:0] prdata;
wire [19:0] pad_out, pad_oe, pad_pu, pad_pd;
wire [4:0] cslew, rslew;
wire [19:0] fin;
int bad_count = 0, checked = 0, cyc = 0;
ptoc_top uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lower_value(lower_value), .func_out(func_out), .func_oe(func_oe),
    .func_pu(func_pu), .func_pd(func_pd), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd), .func_in(fin),
    .clock_output_pad_slew(cslew), .rx_pad_slew(rslew));
initial forever #5 ref_clk = ~ref_clk;
task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
// a hung handshake ends here rather than stalling the run
always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
        bad_count++;
        finish_test();
    end
end
task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
        bad_count++;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
endtask
task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
endtask
task automatic rd(input logic [15:0] a, input logic [31:0] e);
    apb(a, 1'b0, '0);
    check(rdv, e);
endtask
task automatic t_reset();
    check(cslew, 5'h00);
    check(rslew, 5'h08);
    rd(16'h1154, 32'h0);
    rd(16'h1158, 32'h108);
    rd(16'h115c, 32'h0);
    apb(16'h115c, 1'b1, 32'hffff);
    rd(16'h115c, 32'h0);
    rd(16'h1200, 32'h0);
    check(err, 1'b1);
    $display("reset test done");
endtask
task automatic t_drive();
    lower_value <= 16'ha5c3;
    apb(16'h1154, 1'b1, 32'h1a);
    @(posedge ref_clk);
    check(pad_oe, 20'hfffff);
    check(pad_out, 20'haa5c3);
    lower_value <= 16'h3c5a;
    repeat (2) @(posedge ref_clk);
    check(pad_out, 20'ha3c5a);
    $display("drive test done");
endtask
task automatic t_input();
    pad_in <= 20'h5a5a5;
    apb(16'h1154, 1'b1, 32'h30);
    repeat (6) @(posedge ref_clk);
    check(pad_oe, 20'h0);
    check(fin, 20'h5a5a5);
    rd(16'h115c, 32'ha5a5);
    rd(16'h1160, 32'h5);
    $display("input test done");
endtask
task automatic t_func();
    func_oe <= 20'h0ff00;
    func_out <= 20'h12345;
    apb(16'h1154, 1'b1, 32'h2f);
    @(posedge ref_clk);
    check(pad_oe, 20'h0ff00);
    check(pad_out, 20'h12345);
    $display("functional test done");
endtask
task automatic t_pull();
    for (int k = 0; k < 4; k++) begin
        apb(16'h1154, 1'b1, {k[1:0], 7'h40});
        check(pad_pu, {20{k[0]}});
        check(pad_pd, {20{k[1]}});
    end
    apb(16'h1154, 1'b1, 32'h180);
    check(pad_pu, 20'h0f0f0);
    check(pad_pd, 20'h30303);
    $display("pull test done");
endtask
task automatic t_slew();
    logic [4:0] rc [3] = '{5'h08, 5'h0a, 5'h0b};
    for (int k = 0; k < 3; k++) begin
        apb(16'h1154, 1'b1, {k[4:0], 9'h000});
        apb(16'h1158, 1'b1, {rc[k], 5'h00});
        // slew outputs are registered one edge after the write lands
        @(posedge ref_clk);
        check(cslew, k[4:0]);
        check(rslew, rc[k]);
    end
    apb(16'h1154, 1'b1, 32'hffffffff);
    rd(16'h1154, 32'h3fff);
    apb(16'h1158, 1'b1, 32'hffffffff);
    rd(16'h1158, 32'h3ff);
    $display("slew test done");
endtask
initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_drive();
    t_input();
    t_func();
    t_pull();
    t_slew();
    // mid-run reset must bring written registers back to their defaults
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    finish_test();
end
endmodule
